// ### ihm_pkg.sv
// Constants, command and answer carriers and states for the bus master.
// Assumes a 10 MHz core clock and open-drain pads resolved outside.
package ihm_pkg;
  localparam int CLK_NS = 100;
  localparam int SCL_HALF_NS = 5000;
  localparam int HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [3:0] FIRST_BIT = 4'h0;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [3:0] RSVD_TOP = 4'hF;
  localparam logic DIR_READ = 1'h1;
  localparam logic [7:0] ALL_REL = 8'hFF;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10,
    OP_STOP = 2'b11
  } ihm_op_t;

  typedef struct packed {
    ihm_op_t op;
    logic [7:0] data;
    logic ack;
  } ihm_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic ack;
    logic arb_lost;
    logic refused;
  } ihm_rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_RS_REL = 4'b0011,
    ST_RS_HI = 4'b0100,
    ST_BIT_LO = 4'b0101,
    ST_BIT_HI = 4'b0110,
    ST_STOP_LO = 4'b0111,
    ST_STOP_HI = 4'b1000,
    ST_STOP_END = 4'b1001
  } ihm_state_t;
endpackage

// ### ihm_master.sv
// Two-wire bus master: start, restart, address/data bytes, stop.
// Assumes external pull-ups; pads resolve line level from the enables.
//
// How it works
// - SDA changes only while SCL is low
// - START/STOP: SDA edge while SCL high
// - Bus busy between START and STOP
// - Restart keeps ownership, bus stays busy
// - Address packet is nine clocks long
// - Direction bit one reads, zero writes
// - Slave pulls SDA low to acknowledge
// - After address NACK only stop or restart
// - Address shifted out MSB first
// - Address zero is the general call
// - Never send general call with read
// - Addresses 1111xxx are never used
// - Data packet: byte MSB first, then ack
// - Receiver NACKs its final accepted byte
// - START directly followed by STOP is illegal
// - Wait for SCL to rise before high count
// - Multi-master transfers share same composition
// - Lines driven low or released only
`timescale 1ns/1ps
module ihm_master
  import ihm_pkg::*;
#(
  parameter int HALF = HALF_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Command port
  input wire logic cmd_valid,
  input wire ihm_cmd_t cmd,
  output logic cmd_ready,
  // Answer port
  output logic rsp_valid,
  output ihm_rsp_t rsp,
  // Bus state
  output logic bus_busy,
  output logic bus_owned,
  // Clock line
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Data line
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  localparam logic [CNT_W-1:0] HALF_L = CNT_W'(HALF);
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  ihm_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [8:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic [3:0] bit_q, bit_d;
  logic rd_q, rd_d, lost_q, lost_d, first_q, first_d;
  logic nak_q, nak_d, pkt_q, pkt_d, dir_q, dir_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic rsp_valid_q, rsp_valid_d, ready_q, busy_q, busy_d;
  ihm_rsp_t rsp_q, rsp_d;
  logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, scl_p_q, sda_p_q;

  // Line state and decodes
  wire take = cmd_valid & ready_q;
  wire tmo = (cnt_q == '0);
  wire cnt_dn = tmo ? 1'h0 : 1'h1;
  wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire idle_lines = ~busy_q & scl_s_q & sda_s_q;
  wire bad_addr = (cmd.data[7:4] == RSVD_TOP) |
    ((cmd.data[7:1] == GCALL_ADDR) & (cmd.data[0] == DIR_READ));
  wire wr_bad = nak_q | (first_q ? bad_addr : dir_q);
  wire rd_bad = nak_q | first_q | ~dir_q;
  wire stop_bad = ~pkt_q;
  wire tx_bit = ~rd_q & (bit_q != LAST_BIT);
  wire lose = tx_bit & ~sda_oe_q & ~sda_s_q;
  wire last = (bit_q == LAST_BIT);
  wire [CNT_W-1:0] cnt_run = cnt_q - CNT_ONE;
  wire [CNT_W-1:0] cnt_hi = scl_s_q ? cnt_run : HALF_L;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_dn ? cnt_run : cnt_q;
    sh_d = sh_q;
    rx_d = rx_q;
    bit_d = bit_q;
    rd_d = rd_q;
    lost_d = lost_q;
    first_d = first_q;
    nak_d = nak_q;
    pkt_d = pkt_q;
    dir_d = dir_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    rsp_valid_d = 1'h0;
    rsp_d = rsp_q;
    unique case (st_q)
      ST_IDLE: begin
        scl_oe_d = 1'h0;
        sda_oe_d = 1'h0;
        if (take) begin
          if (cmd.op == OP_START && idle_lines) begin
            st_d = ST_START;
            cnt_d = HALF_L;
            sda_oe_d = 1'h1;
            first_d = 1'h1;
            nak_d = 1'h0;
            pkt_d = 1'h0;
          end else begin
            rsp_valid_d = 1'h1;
            rsp_d = '{data: '0, ack: 1'h0, arb_lost: 1'h0, refused: 1'h1};
          end
        end
      end
      ST_START: begin
        if (tmo) begin
          st_d = ST_HOLD;
          scl_oe_d = 1'h1;
        end
      end
      ST_HOLD: begin
        scl_oe_d = 1'h1;
        if (take) begin
          rsp_d = '{data: '0, ack: 1'h0, arb_lost: 1'h0, refused: 1'h1};
          unique case (cmd.op)
            OP_START: begin
              st_d = ST_RS_REL;
              cnt_d = HALF_L;
              sda_oe_d = 1'h0;
              first_d = 1'h1;
              nak_d = 1'h0;
              pkt_d = 1'h0;
            end
            OP_WRITE: begin
              if (wr_bad) begin
                rsp_valid_d = 1'h1;
              end else begin
                st_d = ST_BIT_LO;
                cnt_d = HALF_L;
                sh_d = {cmd.data, 1'h1};
                rd_d = 1'h0;
                bit_d = FIRST_BIT;
                if (first_q) begin
                  dir_d = cmd.data[0];
                end
              end
            end
            OP_READ: begin
              if (rd_bad) begin
                rsp_valid_d = 1'h1;
              end else begin
                st_d = ST_BIT_LO;
                cnt_d = HALF_L;
                sh_d = {ALL_REL, ~cmd.ack};
                rd_d = 1'h1;
                bit_d = FIRST_BIT;
              end
            end
            OP_STOP: begin
              if (stop_bad) begin
                rsp_valid_d = 1'h1;
              end else begin
                st_d = ST_STOP_LO;
                cnt_d = HALF_L;
                sda_oe_d = 1'h1;
              end
            end
          endcase
        end
      end
      ST_RS_REL: begin
        if (tmo) begin
          st_d = ST_RS_HI;
          cnt_d = HALF_L;
          scl_oe_d = 1'h0;
        end
      end
      ST_RS_HI: begin
        cnt_d = cnt_hi;
        if (tmo && scl_s_q) begin
          st_d = ST_START;
          cnt_d = HALF_L;
          sda_oe_d = 1'h1;
        end
      end
      ST_BIT_LO: begin
        sda_oe_d = ~sh_q[8] & ~lost_q;
        if (tmo) begin
          st_d = ST_BIT_HI;
          cnt_d = HALF_L;
          scl_oe_d = 1'h0;
        end
      end
      ST_BIT_HI: begin
        cnt_d = cnt_hi;
        if (lose) begin
          lost_d = 1'h1;
          sda_oe_d = 1'h0;
        end
        if (tmo && scl_s_q) begin
          sh_d = {sh_q[7:0], 1'h1};
          bit_d = bit_q + 4'h1;
          scl_oe_d = 1'h1;
          if (!last) begin
            rx_d = {rx_q[6:0], sda_s_q};
            st_d = ST_BIT_LO;
            cnt_d = HALF_L;
          end else begin
            rsp_valid_d = 1'h1;
            rsp_d = '{data: rx_q, ack: ~sda_s_q, arb_lost: lost_q | lose,
                      refused: 1'h0};
            nak_d = first_q & sda_s_q;
            first_d = 1'h0;
            pkt_d = 1'h1;
            if (lost_q || lose) begin
              st_d = ST_IDLE;
              scl_oe_d = 1'h0;
              sda_oe_d = 1'h0;
              lost_d = 1'h0;
            end else begin
              st_d = ST_HOLD;
            end
          end
        end
      end
      ST_STOP_LO: begin
        if (tmo) begin
          st_d = ST_STOP_HI;
          cnt_d = HALF_L;
          scl_oe_d = 1'h0;
        end
      end
      ST_STOP_HI: begin
        cnt_d = cnt_hi;
        if (tmo && scl_s_q) begin
          st_d = ST_STOP_END;
          cnt_d = HALF_L;
          sda_oe_d = 1'h0;
        end
      end
      ST_STOP_END: begin
        if (tmo) begin
          st_d = ST_IDLE;
          rsp_valid_d = 1'h1;
          rsp_d = '{data: '0, ack: 1'h0, arb_lost: 1'h0, refused: 1'h0};
        end
      end
      default: begin
        st_d = ST_IDLE;
        scl_oe_d = 1'h0;
        sda_oe_d = 1'h0;
      end
    endcase
  end

  // Busy flag follows conditions seen on the wires
  assign busy_d = start_det ? 1'h1 : (stop_det ? 1'h0 : busy_q);

  // Two-stage synchronisers on the line inputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_m_q <= 1'h1;
      scl_s_q <= 1'h1;
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '1;
      rx_q <= '0;
      bit_q <= FIRST_BIT;
      rd_q <= 1'h0;
      lost_q <= 1'h0;
      first_q <= 1'h0;
      nak_q <= 1'h0;
      pkt_q <= 1'h0;
      dir_q <= 1'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      bit_q <= bit_d;
      rd_q <= rd_d;
      lost_q <= lost_d;
      first_q <= first_d;
      nak_q <= nak_d;
      pkt_q <= pkt_d;
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
      rsp_valid_q <= 1'h0;
      rsp_q <= '0;
      ready_q <= 1'h0;
      busy_q <= 1'h0;
      bus_owned <= 1'h0;
      scl_o <= 1'h0;
      sda_o <= 1'h0;
    end else begin
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      ready_q <= (st_d == ST_IDLE) | (st_d == ST_HOLD);
      busy_q <= busy_d;
      bus_owned <= (st_d != ST_IDLE);
      scl_o <= 1'h0;
      sda_o <= 1'h0;
    end
  end

  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign cmd_ready = ready_q;
  assign bus_busy = busy_q;
endmodule

// ### ihm_master_props.sv
// Port checker for the bus master.
// Assumes it is bound into ihm_master.
`timescale 1ns/1ps
module ihm_master_props
  import ihm_pkg::*;
#(
  parameter int HALF = HALF_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Commands, answers and bus state
  input wire logic cmd_valid,
  input wire ihm_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire ihm_rsp_t rsp,
  input wire logic bus_busy,
  input wire logic bus_owned,
  // Lines
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [15:0] hi_q;
  wire take = cmd_valid && cmd_ready;
  wire hi_d = scl_i && !scl_oe;
  // Cycles of released, high clock line
  always_ff @(posedge core_clk or posedge reset)
    if (reset) hi_q <= 16'h0000;
    else hi_q <= hi_d ? hi_q + {15'h0000, hi_q != 16'hFFFF} : 16'h0000;
  sequence start_seq;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence stop_seq;
    $fell(sda_oe) && !scl_oe && scl_i;
  endsequence
  lines_low_only_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  idle_refuse_a: assert property (take && !bus_owned && cmd.op != OP_START
    |=> rsp_valid && rsp.refused) else $error("idle command not refused");
  busy_refuse_a: assert property (take && !bus_owned && bus_busy && cmd.op == OP_START
    |=> rsp_valid && rsp.refused && !bus_owned) else $error("start on busy bus");
  idle_release_a: assert property (!bus_owned && !$past(bus_owned) && !$past(bus_owned, 2)
    |-> !scl_oe && !sda_oe) else $error("idle master drives");
  high_phase_a: assert property ($rose(scl_oe) && bus_owned |-> hi_q >= HALF)
    else $error("high phase short");
  start_hold_a: assert property (start_seq |-> scl_i ##1 (sda_oe && !scl_oe && scl_i) [*3])
    else $error("start not held");
  stop_end_a: assert property (stop_seq |-> ##[1:20] !bus_owned)
    else $error("stop did not end");
  busy_track_a: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:4] bus_busy)
    else $error("busy not set");
endmodule

// ### ihm_slave_model.sv
// Behavioural slave on the wired-AND bus.
// Assumes pull-ups resolve the wires outside.
`timescale 1ns/1ps
module ihm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Wires and clock-stretch enable
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  // Pulls and last byte written
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] last_rx
);
  logic act = 0;
  logic adr = 0;
  logic rd = 0;
  logic first = 0;
  logic [7:0] sr = 8'h00;
  logic [7:0] txb = 8'h00;
  int cnt = 0;
  initial begin
    scl_low = 0;
    sda_low = 0;
    last_rx = 8'h00;
  end
  always @(negedge sda) if (scl) begin
    act = 1;
    first = 1;
    adr = 0;
    cnt = -1;
  end
  always @(posedge sda) if (scl) begin
    act = 0;
    adr = 0;
  end
  always @(posedge scl) if (act) begin
    if (cnt < 8) sr = {sr[6:0], sda};
    else if (rd && sda) adr = 0;
  end
  // Data changes only after the clock has fallen
  always @(negedge scl) if (act) begin
    #20;
    cnt = cnt + 1;
    sda_low = 0;
    if (cnt == 8 && first) begin
      adr = sr[7:1] == ADDR || sr == 8'h00;
      rd = sr[0];
      first = 0;
      txb = last_rx;
      sda_low = adr;
    end else if (cnt == 8 && adr && !rd) begin
      last_rx = sr;
      sda_low = 1;
    end else if (cnt == 8 && adr && rd) begin
      // Next byte to send follows each byte read out
      txb = txb + 8'h01;
    end else if (cnt == 9) cnt = 0;
    if (adr && rd && cnt >= 0 && cnt < 8) sda_low = !txb[7 - cnt];
  end
  always @(negedge scl) if (act && stretch) begin
    scl_low = 1;
    #700;
    scl_low = 0;
  end
endmodule

// ### ihm_master_tb.sv
// Self-checking bench for the bus master with a slave model.
// Assumes the checker binds by port name.
`timescale 1ns/1ps
bind ihm_master ihm_master_props #(.HALF(HALF)) ihm_master_props_i(.core_clk(core_clk),
  .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .bus_busy(bus_busy), .bus_owned(bus_owned),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe));
module ihm_master_tb;
  import ihm_pkg::*;
  logic core_clk = 0;
  logic reset = 1;
  logic cmd_valid = 0;
  logic stretch = 0;
  logic tb_low = 0;
  ihm_cmd_t cmd = '0;
  ihm_rsp_t rsp;
  logic cmd_ready, rsp_valid, bus_busy, bus_owned, scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda;
  logic [7:0] rx, d;
  logic [21:0] e;
  logic [21:0] exp_q[$];
  wire scl = ~(scl_oe | s_scl);
  wire sda = ~(sda_oe | s_sda | tb_low);
  int num_errors = 0;
  int tests_run = 0;
  int seed = 96706;
  localparam logic [21:0] REF = {11'h003, 11'h001};
  localparam logic [21:0] DONE = {11'h003, 11'h000};
  initial forever #50 core_clk = ~core_clk;
  ihm_master #(.HALF(4)) ihm_master_i(.core_clk(core_clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .bus_busy(bus_busy), .bus_owned(bus_owned), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  ihm_slave_model ihm_slave_model_i(.scl(scl), .sda(sda), .stretch(stretch),
    .scl_low(s_scl), .sda_low(s_sda), .last_rx(rx));
  function automatic logic [21:0] ok(input logic [7:0] b, input logic a);
    return {11'h7FF, b, a, 2'b00};
  endfunction
  task automatic check(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic send(input ihm_op_t op, input logic [7:0] dt, input logic ak,
                      input logic [21:0] ex);
    int n;
    @(posedge core_clk);
    if (ex[21:11] != 0) exp_q.push_back(ex);
    cmd_valid <= 1'b1;
    cmd <= '{op, dt, ak};
    n = 0;
    do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++n < 3000);
    cmd_valid <= 1'b0;
    check(n < 3000, "command not taken");
  endtask
  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || bus_owned !== 1'b0) && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    check(n < 3000, "no answer");
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Every answer against the bench's expectation
  always @(posedge core_clk) if (rsp_valid === 1'b1) begin
    check(exp_q.size() > 0, "unexpected answer");
    e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
    check(((rsp ^ e[10:0]) & e[21:11]) == 0, "answer differs");
  end
  initial begin
    #5000000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    d = 8'($random(seed));
    stretch <= 1'b1;
    send(OP_WRITE, d, 1'b0, REF);
    send(OP_START, 8'h00, 1'b0, '0);
    send(OP_WRITE, 8'h54, 1'b0, ok(8'h54, 1'b1));
    send(OP_WRITE, d, 1'b0, ok(d, 1'b1));
    send(OP_STOP, 8'h00, 1'b0, DONE);
    drain;
    check(rx === d && bus_busy === 1'b0, "write lost");
    $display("write test done");
    stretch <= 1'b0;
    send(OP_START, 8'h00, 1'b0, '0);
    send(OP_WRITE, 8'h55, 1'b0, ok(8'h55, 1'b1));
    send(OP_READ, 8'h00, 1'b1, ok(d, 1'b1));
    send(OP_READ, 8'h00, 1'b0, ok(d + 8'h01, 1'b0));
    send(OP_STOP, 8'h00, 1'b0, DONE);
    drain;
    $display("read test done");
    send(OP_START, 8'h00, 1'b0, '0);
    send(OP_WRITE, 8'hF0, 1'b0, REF);
    send(OP_WRITE, 8'h01, 1'b0, REF);
    send(OP_STOP, 8'h00, 1'b0, REF);
    send(OP_WRITE, 8'h22, 1'b0, ok(8'h22, 1'b0));
    send(OP_WRITE, d, 1'b0, REF);
    send(OP_START, 8'h00, 1'b0, '0);
    send(OP_WRITE, 8'h00, 1'b0, ok(8'h00, 1'b1));
    send(OP_WRITE, ~d, 1'b0, ok(~d, 1'b1));
    send(OP_STOP, 8'h00, 1'b0, DONE);
    drain;
    check(rx === ~d, "general call lost");
    $display("call test done");
    send(OP_START, 8'h00, 1'b0, '0);
    send(OP_WRITE, 8'h54, 1'b0, {11'h7FF, 8'h3F, 1'b0, 2'b10});
    tb_low <= 1'b1;
    repeat (2) @(negedge scl);
    @(posedge core_clk);
    tb_low <= 1'b0;
    drain;
    check(bus_busy === 1'b1, "busy lost");
    send(OP_START, 8'h00, 1'b0, REF);
    drain;
    tb_low <= 1'b1;
    repeat (6) @(posedge core_clk);
    tb_low <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(bus_busy === 1'b0, "stop unseen");
    $display("arbitration test done");
    stop_test;
  end
endmodule
